// File: spbc_pkg.sv
package spbc_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] REG_CONTROL_ONE = 3'h0;
    localparam logic [2:0] REG_CONTROL_TWO = 3'h1;
    localparam logic [2:0] REG_BAUD_RATE   = 3'h2;
    localparam logic [2:0] REG_STATUS      = 3'h3;
    localparam logic [2:0] REG_INT_STATUS  = 3'h4;
    localparam logic [2:0] REG_INT_MASK    = 3'h5;

    // Control one fields.
    localparam int BIT_MASTER_SELECT        = 4;
    localparam int BIT_SELECT_OUTPUT_ENABLE = 1;
    localparam logic [7:0] CONTROL_ONE_MASK = 8'h12;

    // Control two fields; bits 7, 6, 5 and 2 hold no storage.
    localparam int BIT_MODE_FAULT_ENABLE    = 4;
    localparam int BIT_BIDIR_OUTPUT_ENABLE  = 3;
    localparam int BIT_STOP_IN_WAIT         = 1;
    localparam int BIT_SINGLE_WIRE_SELECT   = 0;
    localparam logic [7:0] CONTROL_TWO_MASK = 8'h1B;

    // Baud rate fields; bits 7 and 3 hold no storage.
    localparam int PRESCALE_LSB             = 4;
    localparam int RATE_LSB                 = 0;
    localparam logic [7:0] BAUD_RATE_MASK   = 8'h77;

    // Status fields.
    localparam int BIT_RECEIVE_FULL         = 7;
    localparam int BIT_TRANSMIT_EMPTY       = 5;
    localparam int BIT_MODE_FAULT           = 4;

    // Interrupt status and mask fields.
    localparam int INT_RECEIVE_FULL         = 0;
    localparam int INT_MODE_FAULT           = 1;
    localparam logic [7:0] INT_MASK_BITS    = 8'h03;

    localparam logic [7:0] RESET_BYTE       = 8'h00;

    typedef struct packed {
        logic slaveSelectIn;
        logic masterOutIn;
        logic masterInIn;
    } spbc_pins_in_s;

    typedef struct packed {
        logic slaveSelectOut;
        logic slaveSelectOe;
        logic slaveSelectOwned;
        logic masterOutOut;
        logic masterOutOe;
        logic masterOutOwned;
        logic masterInOut;
        logic masterInOe;
        logic masterInOwned;
    } spbc_pins_out_s;

endpackage

// File: spbc_pin_baud.sv
// Summary of operation
// - Control two bits 7, 6, 5 and 2 read back as zero.
// - In slave mode mode-fault enable is ignored; select pin is slave select input.
// - Master without mode-fault enable leaves the select pin to general port control.
// - Master with mode-fault enable uses select pin as fault input or select output.
// - Select output enable picks fault input when clear, select output when set.
// - Single-wire mode: bidir output enable clear makes shared pin input, set drives it.
// - Without single-wire mode the bidir output enable bit is ignored.
// - Stop-in-wait set halts clocks during wait; clear keeps them running.
// - Single-wire slave uses the master-in pin, master uses the master-out pin.
// - Without single-wire mode, separate pins carry data in and data out.
// - Prescale field divides the bus clock by field plus one, one to eight.
// - Rate field divides prescaler output by two to the field plus one.
// - Baud rate register is readable and writable at any moment.
// - Status has three read-only bits; writes to it change nothing.
// - Status bits 6, 3, 2, 1 and 0 read back as zero.
// - Master select sets master when one, slave when zero, steering single-wire pin.
// - Receive-full flag sets when a transfer completes.
module spbc_pin_baud #(
    parameter int ADDR_W = 3
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [ADDR_W-1:0]       regAddr,
    input  wire logic [7:0]              regWriteData,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    output logic      [7:0]              regReadData,
    input  wire spbc_pkg::spbc_pins_in_s pinsIn,
    output spbc_pkg::spbc_pins_out_s     pinsOut,
    input  wire logic                    shiftDataOut,
    output logic                         shiftDataIn,
    input  wire logic                    transferActive,
    input  wire logic                    transferDone,
    input  wire logic                    transmitEmpty,
    input  wire logic                    dataRegisterRead,
    input  wire logic                    baudRun,
    input  wire logic                    waitMode,
    output logic                         clocksRunning,
    output logic                         bitClock,
    output logic                         bitTick,
    output logic                         modeIsMaster,
    output logic                         irq
);

    if (ADDR_W < 3)
    begin
        $error("ADDR_W must be at least 3");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] controlOne;
    logic [7:0] controlTwo;
    logic [7:0] baudRate;
    logic [7:0] intStatus;
    logic [7:0] intMask;
    logic       receiveFull;
    logic       modeFault;
    logic       receiveClearArmed;
    logic       faultClearArmed;
    logic       faultDetect;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] idx);
        hit = (a == ADDR_W'(idx));
    endfunction

    wire logic masterSel          = controlOne[spbc_pkg::BIT_MASTER_SELECT];
    wire logic selectOutputEnable = controlOne[spbc_pkg::BIT_SELECT_OUTPUT_ENABLE];
    wire logic modeFaultEnable    = controlTwo[spbc_pkg::BIT_MODE_FAULT_ENABLE];
    wire logic bidirOutputEnable  = controlTwo[spbc_pkg::BIT_BIDIR_OUTPUT_ENABLE];
    wire logic stopInWait         = controlTwo[spbc_pkg::BIT_STOP_IN_WAIT];
    wire logic singleWire         = controlTwo[spbc_pkg::BIT_SINGLE_WIRE_SELECT];

    wire logic [7:0] statusByte = {receiveFull, 1'b0, transmitEmpty, modeFault, 4'h0};

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            controlOne <= spbc_pkg::RESET_BYTE;
            controlTwo <= spbc_pkg::RESET_BYTE;
            baudRate   <= spbc_pkg::RESET_BYTE;
            intMask    <= spbc_pkg::RESET_BYTE;
        end
        else if (regWrite)
        begin
            // Status writes fall through with no effect.
            if (hit(regAddr, spbc_pkg::REG_CONTROL_ONE))
            begin
                controlOne <= regWriteData & spbc_pkg::CONTROL_ONE_MASK;
            end
            if (hit(regAddr, spbc_pkg::REG_CONTROL_TWO))
            begin
                controlTwo <= regWriteData & spbc_pkg::CONTROL_TWO_MASK;
            end
            if (hit(regAddr, spbc_pkg::REG_BAUD_RATE))
            begin
                baudRate <= regWriteData & spbc_pkg::BAUD_RATE_MASK;
            end
            if (hit(regAddr, spbc_pkg::REG_INT_MASK))
            begin
                intMask <= regWriteData & spbc_pkg::INT_MASK_BITS;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || !regRead)
        begin
            regReadData <= spbc_pkg::RESET_BYTE;
        end
        else if (hit(regAddr, spbc_pkg::REG_CONTROL_ONE))
        begin
            regReadData <= controlOne;
        end
        else if (hit(regAddr, spbc_pkg::REG_CONTROL_TWO))
        begin
            regReadData <= controlTwo;
        end
        else if (hit(regAddr, spbc_pkg::REG_BAUD_RATE))
        begin
            regReadData <= baudRate;
        end
        else if (hit(regAddr, spbc_pkg::REG_STATUS))
        begin
            regReadData <= statusByte;
        end
        else if (hit(regAddr, spbc_pkg::REG_INT_STATUS))
        begin
            regReadData <= intStatus;
        end
        else if (hit(regAddr, spbc_pkg::REG_INT_MASK))
        begin
            regReadData <= intMask;
        end
        else
        begin
            regReadData <= spbc_pkg::RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags. A set in the same cycle as the clearing step always wins.

    wire logic statusRead = regRead && hit(regAddr, spbc_pkg::REG_STATUS);
    wire logic ctrlOneWr  = regWrite && hit(regAddr, spbc_pkg::REG_CONTROL_ONE);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            receiveFull       <= 1'b0;
            receiveClearArmed <= 1'b0;
        end
        else if (transferDone)
        begin
            receiveFull       <= 1'b1;
            receiveClearArmed <= 1'b0;
        end
        else if (statusRead && receiveFull)
        begin
            receiveClearArmed <= 1'b1;
        end
        else if (dataRegisterRead && receiveClearArmed)
        begin
            receiveFull       <= 1'b0;
            receiveClearArmed <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            modeFault       <= 1'b0;
            faultClearArmed <= 1'b0;
        end
        else if (faultDetect)
        begin
            modeFault       <= 1'b1;
            faultClearArmed <= 1'b0;
        end
        else if (statusRead && modeFault)
        begin
            faultClearArmed <= 1'b1;
        end
        else if (ctrlOneWr && faultClearArmed)
        begin
            modeFault       <= 1'b0;
            faultClearArmed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, and the masked level output.

    logic [7:0] intEvents;

    always_comb
    begin
        intEvents                             = 8'h00;
        intEvents[spbc_pkg::INT_RECEIVE_FULL] = transferDone;
        intEvents[spbc_pkg::INT_MODE_FAULT]   = faultDetect;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            intStatus <= spbc_pkg::RESET_BYTE;
        end
        else if (regWrite && hit(regAddr, spbc_pkg::REG_INT_STATUS))
        begin
            intStatus <= (intStatus & ~regWriteData) | intEvents;
        end
        else
        begin
            intStatus <= intStatus | intEvents;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((intStatus & ~({8{regWrite && hit(regAddr, spbc_pkg::REG_INT_STATUS)}} & regWriteData))
                     | intEvents) & intMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin steering. The select pin is sampled as an ordinary synchronous input.

    spbc_pkg::spbc_pins_out_s next_pinsOut;
    logic                     next_shiftDataIn;

    // Fault input role only exists as master with fault enable and no select output.
    assign faultDetect = masterSel && modeFaultEnable && !selectOutputEnable && !pinsIn.slaveSelectIn;

    always_comb
    begin
        next_pinsOut     = '0;
        next_shiftDataIn = 1'b0;
        if (!masterSel)
        begin
            // Fault enable has no say here.
            next_pinsOut.slaveSelectOwned = 1'b1;
        end
        else if (modeFaultEnable)
        begin
            next_pinsOut.slaveSelectOwned = 1'b1;
            next_pinsOut.slaveSelectOe    = selectOutputEnable;
            next_pinsOut.slaveSelectOut   = selectOutputEnable ? !transferActive : 1'b1;
        end
        else
        begin
            next_pinsOut.slaveSelectOwned = 1'b0;
        end

        if (singleWire)
        begin
            if (masterSel)
            begin
                next_pinsOut.masterOutOwned = 1'b1;
                next_pinsOut.masterOutOe    = bidirOutputEnable;
                next_pinsOut.masterOutOut   = shiftDataOut;
                next_shiftDataIn            = pinsIn.masterOutIn;
            end
            else
            begin
                next_pinsOut.masterInOwned  = 1'b1;
                next_pinsOut.masterInOe     = bidirOutputEnable;
                next_pinsOut.masterInOut    = shiftDataOut;
                next_shiftDataIn            = pinsIn.masterInIn;
            end
        end
        else
        begin
            // Direction is fixed by the role, and a slave drives only while selected.
            next_pinsOut.masterOutOwned = 1'b1;
            next_pinsOut.masterInOwned  = 1'b1;
            if (masterSel)
            begin
                next_pinsOut.masterOutOe  = 1'b1;
                next_pinsOut.masterOutOut = shiftDataOut;
                next_shiftDataIn          = pinsIn.masterInIn;
            end
            else
            begin
                // A deselected slave keeps off the shared return line.
                next_pinsOut.masterInOe   = !pinsIn.slaveSelectIn;
                next_pinsOut.masterInOut  = shiftDataOut;
                next_shiftDataIn          = pinsIn.masterOutIn;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pinsOut      <= '0;
            shiftDataIn  <= 1'b0;
            modeIsMaster <= 1'b0;
        end
        else
        begin
            pinsOut      <= next_pinsOut;
            shiftDataIn  <= next_shiftDataIn;
            modeIsMaster <= masterSel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wait-mode clock gate.

    wire logic next_clocksRunning = !(waitMode && stopInWait);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clocksRunning <= 1'b1;
        end
        else
        begin
            clocksRunning <= next_clocksRunning;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud generator: prescale counter feeding a half-period counter of 2^rate.

    logic [2:0] prescaleCount;
    logic [7:0] halfCount;
    wire logic [2:0] prescaleSel = baudRate[spbc_pkg::PRESCALE_LSB +: 3];
    wire logic [2:0] rateSel     = baudRate[spbc_pkg::RATE_LSB +: 3];
    wire logic       genRun      = baudRun && next_clocksRunning;
    wire logic       prescaleTick = genRun && (prescaleCount == prescaleSel);
    wire logic [7:0] halfLimit   = 8'(8'h01 << rateSel) - 8'h01;
    wire logic       halfDone    = prescaleTick && (halfCount == halfLimit);

    always_ff @(posedge clk_sys)
    begin
        if (rst || !genRun)
        begin
            prescaleCount <= 3'h0;
        end
        else if (prescaleTick)
        begin
            prescaleCount <= 3'h0;
        end
        else
        begin
            prescaleCount <= prescaleCount + 3'h1;
        end
    end

    // Rewriting the divisors mid-count is harmless: the compare simply hits later.
    always_ff @(posedge clk_sys)
    begin
        if (rst || !genRun)
        begin
            halfCount <= 8'h00;
        end
        else if (halfDone)
        begin
            halfCount <= 8'h00;
        end
        else if (prescaleTick)
        begin
            halfCount <= halfCount + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || !baudRun)
        begin
            bitClock <= 1'b0;
            bitTick  <= 1'b0;
        end
        else
        begin
            bitClock <= halfDone ? !bitClock : bitClock;
            bitTick  <= halfDone && bitClock;
        end
    end

endmodule

// File: spbc_far_device.sv
// Far serial device: it answers at once and always drives the data pin that the block leaves as input.
module spbc_far_device (
    input  wire spbc_pkg::spbc_pins_out_s pinsOut,
    input  wire logic                     selectAssert,
    input  wire logic                     farData,
    output wire spbc_pkg::spbc_pins_in_s  pinsIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // The select line has a pull-up, so it reads high when nobody pulls it low.
    assign pinsIn.slaveSelectIn = pinsOut.slaveSelectOe ? pinsOut.slaveSelectOut : !selectAssert;
    assign pinsIn.masterOutIn   = pinsOut.masterOutOe ? pinsOut.masterOutOut : farData;
    assign pinsIn.masterInIn    = pinsOut.masterInOe ? pinsOut.masterInOut : farData;
endmodule

// File: spbc_pin_baud_checker.sv
module spbc_pin_baud_checker #(
    parameter int ADDR_W = 3
) (
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire logic [ADDR_W-1:0]        regAddr,
    input wire logic [7:0]               regWriteData,
    input wire logic                     regWrite,
    input wire logic                     regRead,
    input wire logic [7:0]               regReadData,
    input wire spbc_pkg::spbc_pins_out_s pinsOut,
    input wire logic                     transferActive,
    input wire logic                     transferDone,
    input wire logic                     baudRun,
    input wire logic                     waitMode,
    input wire logic                     clocksRunning,
    input wire logic                     bitClock,
    input wire logic                     bitTick,
    input wire logic                     modeIsMaster
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pin outputs still hold reset values at the first edge after release.
    logic settled;
    always_ff @(posedge clk_sys)
    begin
        settled <= !rst;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    AST_CTRL_TWO_ZERO: assert property (regRead && regAddr == ADDR_W'(spbc_pkg::REG_CONTROL_TWO)
        |=> regReadData[7:5] == 3'h0 && !regReadData[2]) else $error("control two unused bit nonzero");
    AST_STATUS_ZERO: assert property (regRead && regAddr == ADDR_W'(spbc_pkg::REG_STATUS)
        |=> !regReadData[6] && regReadData[3:0] == 4'h0) else $error("status unused bit nonzero");
    AST_BAUD_ANYTIME: assert property (regWrite && regAddr == ADDR_W'(spbc_pkg::REG_BAUD_RATE)
        ##2 regRead && regAddr == ADDR_W'(spbc_pkg::REG_BAUD_RATE)
        |=> regReadData == ($past(regWriteData, 3) & 8'h77)) else $error("baud readback wrong");
    AST_RX_FULL: assert property (transferDone ##[1:4] (regRead && regAddr == ADDR_W'(spbc_pkg::REG_STATUS))
        |=> regReadData[7]) else $error("receive full not set");
    AST_SLAVE_SELECT_IN: assert property (settled && !modeIsMaster
        |-> pinsOut.slaveSelectOwned && !pinsOut.slaveSelectOe) else $error("slave select not an input");
    AST_SELECT_OUT: assert property (pinsOut.slaveSelectOe |-> modeIsMaster && pinsOut.slaveSelectOwned
        && pinsOut.slaveSelectOut == !$past(transferActive)) else $error("select output wrong");
    AST_MASTER_IN_PIN: assert property (settled && modeIsMaster |-> !pinsOut.masterInOe)
        else $error("master drives data-in pin");
    AST_SLAVE_IN_PIN: assert property (settled && !modeIsMaster |-> !pinsOut.masterOutOe)
        else $error("slave drives master-out pin");
    AST_WAIT_RUN: assert property (settled && !$past(waitMode) |-> clocksRunning)
        else $error("clocks stopped outside wait");
    AST_TICK_SPACING: assert property (bitTick |=> !bitTick)
        else $error("bit ticks too close");
    AST_BAUD_IDLE: assert property (!baudRun [*3] |-> !bitClock && !bitTick)
        else $error("bit clock runs while idle");
endmodule

bind spbc_pin_baud spbc_pin_baud_checker #(.ADDR_W(ADDR_W)) chk_u (
    .clk_sys, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .pinsOut, .transferActive,
    .transferDone, .baudRun, .waitMode, .clocksRunning, .bitClock, .bitTick, .modeIsMaster
);

// File: test_spbc_pin_baud.sv
module test_spbc_pin_baud;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWriteData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regReadData;
    logic       shiftDataOut = 1'b0;
    logic       shiftDataIn;
    logic       transferActive = 1'b0;
    logic       transferDone = 1'b0;
    logic       transmitEmpty = 1'b0;
    logic       dataRegisterRead = 1'b0;
    logic       baudRun = 1'b0;
    logic       waitMode = 1'b0;
    logic       clocksRunning, bitClock, bitTick, modeIsMaster, irq;
    logic       selectAssert = 1'b1;
    logic       farData = 1'b0;
    logic       m, mfe, soe, sws, bo;
    logic [5:0] expPins;
    int         fails = 0;
    int         nChecks = 0;
    int         cycles = 0;
    spbc_pkg::spbc_pins_in_s  pinsIn;
    spbc_pkg::spbc_pins_out_s pinsOut;

    spbc_pin_baud dut_u (
        .clk_sys, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .pinsIn, .pinsOut,
        .shiftDataOut, .shiftDataIn, .transferActive, .transferDone, .transmitEmpty, .dataRegisterRead,
        .baudRun, .waitMode, .clocksRunning, .bitClock, .bitTick, .modeIsMaster, .irq
    );
    spbc_far_device far_u (.pinsOut, .selectAssert, .farData, .pinsIn);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        check(16'(regReadData), 16'(exp));
    endtask

    task automatic settle();
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic baud(input int p, input int r);
        int n;
        wr(spbc_pkg::REG_BAUD_RATE, 8'(p * 16 + r));
        @(posedge clk_sys) baudRun <= 1'b1;
        n = 0;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(negedge clk_sys);
                n++;
            end
            while (bitTick !== 1'b1 && n < 600);
        end
        check(16'(n), 16'((p + 1) * (2 << r)));
        @(posedge clk_sys) baudRun <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        wr(3'h6, 8'hFF);
        for (int i = 0; i < 8; i++)
            rdc(3'(i), 8'h00);
        wr(spbc_pkg::REG_CONTROL_TWO, 8'hFF);
        rdc(spbc_pkg::REG_CONTROL_TWO, 8'h1B);
        @(posedge clk_sys) transmitEmpty <= 1'b1;
        wr(spbc_pkg::REG_STATUS, 8'hFF);
        rdc(spbc_pkg::REG_STATUS, 8'h20);
        @(posedge clk_sys) transferActive <= 1'b1;
        wr(spbc_pkg::REG_BAUD_RATE, 8'hFF);
        rdc(spbc_pkg::REG_BAUD_RATE, 8'h77);
        for (int i = 0; i < 32; i++)
        begin
            {m, mfe, soe, sws, bo} = 5'(i);
            @(posedge clk_sys);
            selectAssert <= !m;
            farData <= bo ^ soe;
            transferActive <= sws;
            shiftDataOut <= soe;
            wr(spbc_pkg::REG_CONTROL_ONE, {3'h0, m, 2'h0, soe, 1'b0});
            wr(spbc_pkg::REG_CONTROL_TWO, {3'h0, mfe, bo, 2'h0, sws});
            settle();
            expPins = {!m | mfe, m & mfe & soe, !(sws & !m), m & (!sws | bo), !(sws & m), !m & (!sws | bo)};
            check(16'({pinsOut.slaveSelectOwned, pinsOut.slaveSelectOe, pinsOut.masterOutOwned,
                pinsOut.masterOutOe, pinsOut.masterInOwned, pinsOut.masterInOe}), 16'(expPins));
            check(16'(modeIsMaster), 16'(m));
            if (!(sws & bo))
                check(16'(shiftDataIn), 16'(farData));
            else
                check(16'(shiftDataIn), 16'(soe));
        end
        wr(spbc_pkg::REG_CONTROL_TWO, 8'h02);
        @(posedge clk_sys) waitMode <= 1'b1;
        settle();
        check(16'(clocksRunning), 16'h0000);
        wr(spbc_pkg::REG_CONTROL_TWO, 8'h00);
        settle();
        check(16'(clocksRunning), 16'h0001);
        @(posedge clk_sys) waitMode <= 1'b0;
        for (int i = 0; i < 8; i++)
            baud(i, 7 - i);
        wr(spbc_pkg::REG_INT_MASK, 8'h00);
        @(posedge clk_sys) transferDone <= 1'b1;
        @(posedge clk_sys) transferDone <= 1'b0;
        rdc(spbc_pkg::REG_STATUS, 8'hA0);
        check(16'(irq), 16'h0000);
        rdc(spbc_pkg::REG_INT_STATUS, 8'h01);
        wr(spbc_pkg::REG_INT_MASK, 8'h01);
        settle();
        check(16'(irq), 16'h0001);
        @(posedge clk_sys) dataRegisterRead <= 1'b1;
        @(posedge clk_sys) dataRegisterRead <= 1'b0;
        wr(spbc_pkg::REG_INT_STATUS, 8'h01);
        settle();
        check(16'(irq), 16'h0000);
        rdc(spbc_pkg::REG_STATUS, 8'h20);
        // A master whose select pin is the fault input sees another master pull that pin low.
        wr(spbc_pkg::REG_CONTROL_ONE, 8'h10);
        @(posedge clk_sys) selectAssert <= 1'b1;
        wr(spbc_pkg::REG_CONTROL_TWO, 8'h10);
        settle();
        rdc(spbc_pkg::REG_STATUS, 8'h30);
        rdc(spbc_pkg::REG_INT_STATUS, 8'h02);
        give_verdict();
    end
endmodule
